/* art_pkg.sv */
// art_pkg: constants for the adaptive receiver tuning block
// assumes a byte-wide configuration store read port, byte valid while the strobe is high
package art_pkg;
  localparam logic [7:0] ART_SIZE_ADDR   = 8'h97;  // lookup_table_size_byte location
  localparam logic [7:0] ART_LUT_BASE    = 8'h98;  // first waveshaping entry, follows size byte
  localparam int         ART_MAX_ENTRIES = 20;     // shared entries, both tables
  localparam int         ART_ENTRY_BYTES = 4;      // one dword per entry
  localparam int         ART_MAX_BYTES   = 80;     // shared table bytes
  // entry field positions
  localparam int ART_MASK_LSB  = 16;
  localparam int ART_PEAK_LSB  = 13;
  localparam int ART_LEVEL_LSB = 10;
  localparam int ART_GAIN_LSB  = 7;
  localparam int ART_HPCF_LSB  = 4;
  localparam int ART_GEAR_LSB  = 0;
  localparam int ART_DELTA_W   = 3;
  localparam int ART_GEAR_W    = 4;
  localparam int ART_MASK_W    = 16;
  // register field widths
  localparam int ART_GAIN_W    = 2;
  localparam int ART_HPCF_W    = 2;
  localparam int ART_LEVEL_W   = 4;
  localparam int ART_PEAK_W    = 4;
  typedef enum logic [2:0] {
    ART_IDLE, ART_SIZE_RD, ART_SIZE_WT, ART_BYTE_RD, ART_BYTE_WT, ART_APPLY
  } art_state_t;
endpackage : art_pkg

/* art_sat_add.sv */
// art_sat_add: applies a sign-magnitude delta to an unsigned field with saturation
// assumes delta msb is the sign, lower two bits the magnitude
`timescale 1ns/1ps
module art_sat_add #(
  parameter int W = 2
) (
  input  wire logic [W-1:0] cur,    // current field value
  input  wire logic [2:0]   delta,  // sign + magnitude
  output logic      [W-1:0] res     // saturated result
);
  localparam logic [W:0] FMAX = {1'b0, {W{1'b1}}};
  initial begin
    if (W < 2) $error("art_sat_add: W below 2");
  end
  logic [W:0] mag;
  logic [W:0] ext;
  logic [W:0] sum;
  // widen by one bit so the overflow or borrow is visible
  always_comb begin
    mag = (W+1)'(delta[1:0]);
    ext = {1'b0, cur};
    sum = ext + mag;
    res = cur;
    if (delta[2]) begin
      res = (ext < mag) ? '0 : W'(ext - mag);
    end else begin
      res = (sum > FMAX) ? FMAX[W-1:0] : sum[W-1:0];
    end
  end
endmodule // art_sat_add

/* art_lut_update.sv */
// art_lut_update: adaptive receiver tuning, scans the receiver lookup table
// assumes a byte read port into configuration store, data valid while the strobe is high
// Functional notes
// R1 - only gain, highpass corner, floor level and floor peak fields get adjusted
// R2 - entry count is upper nibble of size byte at location 0x97
// R3 - zero count disables all receiver updates
// R4 - both tables share 20 dword entries plus one length byte
// R5 - receiver table starts right after last waveshaping entry
// R6 - resizing waveshaping table invalidates stored receiver entries; rewrite them
// R7 - table results override defaults loaded by protocol load
// R8 - every gear change scans table and applies matching entries
// R9 - bits 31:16 hold one-hot technology and baud mask
// R10 - bits 15:13 change the floor peak threshold
// R11 - bits 12:10 change the floor level threshold, range +/-3
// R12 - bits 9:7 change receiver gain, range +/-3
// R13 - bits 6:4 change highpass corner, range +/-3
// R14 - bits 3:0 give gear number the entry applies at
// R15 - entries stored in ascending gear order
// R16 - changes of matching entries up to current gear accumulate
// R17 - protocol load with new protocol or baud also triggers lookup
// R18 - msb of delta is sign, two bits magnitude, fields saturate
`timescale 1ns/1ps
module art_lut_update
  import art_pkg::*;
#(
  parameter int MAX_ENTRIES = ART_MAX_ENTRIES
) (
  input  wire logic                   mclk,            // core clock, 10 MHz
  input  wire logic                   reset_n,         // async reset, active low
  input  wire logic                   clk_en,          // freezes all state when low
  input  wire logic [ART_GEAR_W-1:0]  power_gear,      // active gear from power control
  input  wire logic [ART_MASK_W-1:0]  mode_onehot,     // current technology and baud
  input  wire logic                   protocol_load_cmd, // pulse: protocol load done
  input  wire logic [ART_GAIN_W-1:0]  dflt_gain,       // gain from protocol load
  input  wire logic [ART_HPCF_W-1:0]  dflt_hpcf,       // corner from protocol load
  input  wire logic [ART_LEVEL_W-1:0] dflt_level,      // floor level from protocol load
  input  wire logic [ART_PEAK_W-1:0]  dflt_peak,       // floor peak from protocol load
  output logic                        cfg_rd,          // store read strobe
  output logic [7:0]                  cfg_addr,        // store byte address
  input  wire logic [7:0]             cfg_data,        // store byte, valid while strobe high
  output logic [ART_GAIN_W-1:0]       rx_gain,         // receiver_control_reg gain
  output logic [ART_HPCF_W-1:0]       highpass_corner_select, // receiver_control_reg corner
  output logic [ART_LEVEL_W-1:0]      signal_floor_level,     // reader_sigproc_config level
  output logic [ART_PEAK_W-1:0]       signal_floor_peak_threshold, // reader_sigproc_config
  output logic                        busy             // scan in progress
);
  initial begin
    if (MAX_ENTRIES < 1 || MAX_ENTRIES > ART_MAX_ENTRIES)
      $error("art_lut_update: MAX_ENTRIES out of range");
  end

  // scan timeline, one line per enabled edge, c0 being the trigger edge:
  //   c0 gear change or protocol load seen, pending flag set
  //   c1 idle sees pending, fields back to defaults, strobe to size byte
  //   c2 size byte taken while the strobe stands; count zero ends here
  //   c3 byte read state raises the strobe for entry byte 0
  //   c4 byte 0 taken, back to byte read
  //   ... two edges per byte, four bytes per entry
  //   apply edge lays the entry on the fields and moves to the next one
  // worst case is two edges for the size byte plus nine per entry
  //
  // the store port has no wait: the byte must stand on cfg_data while
  // cfg_rd is high, so a store with registered output needs a bypass
  //
  // limitation: the mode mask is sampled once at scan start; a mode change
  // without a protocol load is not noticed until the next trigger
  //
  // limitation: triggers during a scan collapse into one pending rescan,
  // so a burst of gear steps costs at most one extra scan
  //
  // trade-off: every scan restarts from the protocol defaults, which costs
  // a full rescan on each gear step but keeps accumulation exact when the
  // gear goes down as well as up

  // sequencer state
  art_state_t             st_q;
  art_state_t             st_d;
  // trigger tracking
  logic [ART_GEAR_W-1:0]  gear_q;
  logic [ART_GEAR_W-1:0]  gear_d;
  logic [ART_MASK_W-1:0]  mode_q;
  logic [ART_MASK_W-1:0]  mode_d;
  logic                   pend_q;
  logic                   pend_d;
  // table walk
  logic [4:0]             idx_q;      // entry index within receiver table
  logic [4:0]             idx_d;
  logic [4:0]             cnt_q;      // receiver entry count
  logic [4:0]             cnt_d;
  logic [4:0]             base_q;     // waveshaping count = first receiver entry
  logic [4:0]             base_d;
  logic [1:0]             byte_q;     // byte within the entry
  logic [1:0]             byte_d;
  logic [31:0]            ent_q;      // entry being assembled
  logic [31:0]            ent_d;
  // adjusted receiver fields
  logic [ART_GAIN_W-1:0]  gain_q;
  logic [ART_GAIN_W-1:0]  gain_d;
  logic [ART_HPCF_W-1:0]  hpcf_q;
  logic [ART_HPCF_W-1:0]  hpcf_d;
  logic [ART_LEVEL_W-1:0] lvl_q;
  logic [ART_LEVEL_W-1:0] lvl_d;
  logic [ART_PEAK_W-1:0]  peak_q;
  logic [ART_PEAK_W-1:0]  peak_d;
  // store port
  logic                   cfg_rd_d;
  logic [7:0]             cfg_addr_q;
  logic [7:0]             cfg_addr_d;
  logic [ART_GAIN_W-1:0]  gain_n;
  logic [ART_HPCF_W-1:0]  hpcf_n;
  logic [ART_LEVEL_W-1:0] lvl_n;
  logic [ART_PEAK_W-1:0]  peak_n;
  logic                   hit;
  logic [4:0]             ws_n;       // waveshaping count from size byte
  logic [4:0]             rx_n;       // receiver count, clipped
  logic [4:0]             rx_lim;     // room left for receiver entries
  logic [7:0]             ent_addr;

  // saturating adders, one per adjustable field
  // gain and corner are two-bit codes, so a +/-3 step spans their whole range
  art_sat_add #(.W(ART_GAIN_W)) u_gain (
    .cur   (gain_q),
    .delta (ent_q[ART_GAIN_LSB +: ART_DELTA_W]), // [R12] [R18]
    .res   (gain_n)
  );
  art_sat_add #(.W(ART_HPCF_W)) u_hpcf (
    .cur   (hpcf_q),
    .delta (ent_q[ART_HPCF_LSB +: ART_DELTA_W]), // [R13] [R18]
    .res   (hpcf_n)
  );
  art_sat_add #(.W(ART_LEVEL_W)) u_lvl (
    .cur   (lvl_q),
    .delta (ent_q[ART_LEVEL_LSB +: ART_DELTA_W]), // [R11] [R18]
    .res   (lvl_n)
  );
  art_sat_add #(.W(ART_PEAK_W)) u_peak (
    .cur   (peak_q),
    .delta (ent_q[ART_PEAK_LSB +: ART_DELTA_W]), // [R10] [R18]
    .res   (peak_n)
  );

  // entry matches mode and gear at or below the active one
  assign hit = |(ent_q[ART_MASK_LSB +: ART_MASK_W] & mode_q)             // [R9]
             && (ent_q[ART_GEAR_LSB +: ART_GEAR_W] <= gear_q);           // [R14] [R16]

  // size byte split; receiver count clipped to the room the waveshaping entries leave
  always_comb begin
    ws_n   = {1'b0, cfg_data[3:0]};
    rx_n   = {1'b0, cfg_data[7:4]};                                      // [R2]
    rx_lim = 5'(MAX_ENTRIES) - ws_n;                                     // [R4]
    if (ws_n > 5'(MAX_ENTRIES)) rx_lim = '0;
    if (rx_n > rx_lim) rx_n = rx_lim;
    ent_addr = ART_LUT_BASE + 8'({base_q + idx_q, 2'b00}) + 8'(byte_q);  // [R5]
  end

  // sequencer: fetch size byte, then each receiver entry, byte by byte
  always_comb begin
    st_d = st_q;
    gear_d = gear_q;
    mode_d = mode_q;
    pend_d = pend_q;
    idx_d = idx_q;
    cnt_d = cnt_q;
    base_d = base_q;
    byte_d = byte_q;
    ent_d = ent_q;
    gain_d = gain_q;
    hpcf_d = hpcf_q;
    lvl_d = lvl_q;
    peak_d = peak_q;
    cfg_rd_d = 1'b0;
    cfg_addr_d = cfg_addr_q;
    // a trigger arriving mid-scan is held and restarts the scan afterwards
    if (power_gear != gear_q || protocol_load_cmd) pend_d = 1'b1;          // [R8] [R17]
    gear_d = power_gear;
    if (protocol_load_cmd) begin
      // defaults are the base; table deltas are then laid on top
      gain_d = dflt_gain; // [R7]
      hpcf_d = dflt_hpcf;
      lvl_d = dflt_level;
      peak_d = dflt_peak;
    end
    case (st_q)
      // idle: wait for a trigger, then ask for the size byte
      ART_IDLE: begin
        if (pend_q) begin
          pend_d = 1'b0;
          mode_d = mode_onehot;
          // rescan from protocol defaults so accumulation is not repeated
          gain_d = dflt_gain; // [R16]
          hpcf_d = dflt_hpcf;
          lvl_d = dflt_level;
          peak_d = dflt_peak;
          cfg_rd_d = 1'b1;
          cfg_addr_d = ART_SIZE_ADDR;
          st_d = ART_SIZE_WT;
        end
      end
      // size byte stands on the port now
      ART_SIZE_WT: begin
        base_d = ws_n;
        cnt_d = rx_n;
        idx_d = '0;
        byte_d = '0;
        if (rx_n == '0) begin
          // zero count: leave the receiver fields at protocol defaults
          st_d = ART_IDLE;                                               // [R3]
        end else begin
          st_d = ART_BYTE_RD;
        end
      end
      // strobe one entry byte
      ART_BYTE_RD: begin
        cfg_rd_d = 1'b1;
        cfg_addr_d = ent_addr;
        st_d = ART_BYTE_WT;
      end
      // take the byte while the strobe stands
      ART_BYTE_WT: begin
        // entries are little-endian dwords
        ent_d = {cfg_data, ent_q[31:8]};
        byte_d = byte_q + 2'd1;
        st_d = (byte_q == 2'd3) ? ART_APPLY : ART_BYTE_RD;
      end
      // whole entry assembled: lay it on the fields if it matches
      ART_APPLY: begin
        if (hit) begin
          gain_d = gain_n; // [R1] [R8]
          hpcf_d = hpcf_n;
          lvl_d = lvl_n;
          peak_d = peak_n;
        end
        idx_d = idx_q + 5'd1;
        // ascending order lets the scan stop at the first higher gear
        if (idx_q + 5'd1 >= cnt_q ||
            ent_q[ART_GEAR_LSB +: ART_GEAR_W] > gear_q) st_d = ART_IDLE; // [R15]
        else st_d = ART_BYTE_RD;
      end
      // unused code points fall back to idle
      default: st_d = ART_IDLE;
    endcase
  end

  // state registers only; a scan is pending out of reset so the
  // fields pick up the defaults and the table without a trigger
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= ART_IDLE;
      gear_q <= '0;
      mode_q <= '0;
      pend_q <= 1'b1;
      idx_q <= '0;
      cnt_q <= '0;
      base_q <= '0;
      byte_q <= '0;
      ent_q <= '0;
      gain_q <= '0;
      hpcf_q <= '0;
      lvl_q <= '0;
      peak_q <= '0;
      cfg_rd <= 1'b0;
      cfg_addr_q <= '0;
    end else if (clk_en) begin
      st_q <= st_d;
      gear_q <= gear_d;
      mode_q <= mode_d;
      pend_q <= pend_d;
      idx_q <= idx_d;
      cnt_q <= cnt_d;
      base_q <= base_d;
      byte_q <= byte_d;
      ent_q <= ent_d;
      gain_q <= gain_d;
      hpcf_q <= hpcf_d;
      lvl_q <= lvl_d;
      peak_q <= peak_d;
      cfg_rd <= cfg_rd_d;
      cfg_addr_q <= cfg_addr_d;
    end
  end

  // outputs straight from flip-flops, busy decoded from the state register
  assign cfg_addr = cfg_addr_q;
  assign rx_gain = gain_q;
  assign highpass_corner_select = hpcf_q;
  assign signal_floor_level = lvl_q;
  assign signal_floor_peak_threshold = peak_q;
  assign busy = (st_q != ART_IDLE);
endmodule // art_lut_update

/* art_lut_update_checker.sv */
// art_lut_update_checker: port assertions for the receiver table scanner
// assumes a bind to art_lut_update running with clk_en held high
`timescale 1ns/1ps
module art_lut_update_checker
  import art_pkg::*;
#(parameter int MAX_ENTRIES = ART_MAX_ENTRIES) (
  input wire logic                   mclk,                        // clock
  input wire logic                   reset_n,                     // reset
  input wire logic                   protocol_load_cmd,           // load pulse
  input wire logic                   cfg_rd,                      // strobe
  input wire logic [7:0]             cfg_addr,                    // address
  input wire logic [7:0]             cfg_data,                    // store byte
  input wire logic [ART_GAIN_W-1:0]  rx_gain,                     // gain
  input wire logic [ART_HPCF_W-1:0]  highpass_corner_select,      // corner
  input wire logic [ART_LEVEL_W-1:0] signal_floor_level,          // level
  input wire logic [ART_PEAK_W-1:0]  signal_floor_peak_threshold, // peak
  input wire logic                   busy                         // scanning
);
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  // strobe shape and address window
  a_rd_single: assert property (cfg_rd |=> !cfg_rd)
    else $error("read strobe held two cycles");
  a_rd_table: assert property (cfg_rd |->
    cfg_addr == ART_SIZE_ADDR || cfg_addr - ART_LUT_BASE < 8'd80) else $error("read off table");
  a_size_first: assert property ($rose(busy) |-> ##[0:1] (cfg_rd && cfg_addr == ART_SIZE_ADDR))
    else $error("scan did not open with the size byte");
  // an empty receiver table ends the scan at once
  a_zero_quit: assert property (cfg_rd && cfg_addr == ART_SIZE_ADDR &&
    (cfg_data[7:4] == 4'h0) |=> !busy && !cfg_rd) else $error("scan went on with no entries");
  // first entry sits right behind the waveshape entries
  a_first_entry: assert property (cfg_rd && cfg_addr == ART_SIZE_ADDR &&
    (cfg_data[7:4] != 4'h0) |-> ##2 cfg_rd &&
    cfg_addr == ART_LUT_BASE + {$past(cfg_data[3:0], 2), 2'b00})
    else $error("first entry address wrong");
  a_byte_order: assert property (cfg_rd && cfg_addr[1:0] != 2'h3 |->
    ##2 cfg_rd && cfg_addr == $past(cfg_addr, 2) + 8'h01) else $error("entry bytes out of order");
  a_scan_ends: assert property ($rose(busy) |-> ##[1:250] !busy)
    else $error("scan ran too long");
  // fields move only at a scan or a protocol load
  a_hold_idle: assert property (!busy && !$past(busy) && !$past(protocol_load_cmd) |->
    $stable({rx_gain, highpass_corner_select, signal_floor_level, signal_floor_peak_threshold}))
    else $error("fields changed while idle");
endmodule // art_lut_update_checker

/* art_store_model.sv */
// art_store_model: configuration store model with a byte read port
// assumes one-cycle strobes; the byte stands while the strobe is high
`timescale 1ns/1ps
module art_store_model (
  input  wire logic       mclk,     // core clock
  input  wire logic       cfg_rd,   // read strobe
  input  wire logic [7:0] cfg_addr, // byte address
  output logic      [7:0] cfg_data  // read byte
);
  logic [7:0] mem [256] = '{default: 8'h00}; // bench fills it, gears ascending
  logic [7:0] last_q = 8'h00; // last byte handed out
  // the scanner takes the byte at the edge that sees its strobe high
  always @(posedge mclk) if (cfg_rd) last_q <= mem[cfg_addr];
  // released port shows the inverse of the last byte so a late sample cannot match
  assign cfg_data = cfg_rd ? mem[cfg_addr] : ~last_q;
endmodule // art_store_model

/* art_lut_update_bench.sv */
// art_lut_update_bench: gear and protocol sequences against the store model
// assumes design, store model and checker compiled first
`timescale 1ns/1ps
module art_lut_update_bench;
  import art_pkg::*;
  logic        mclk = 1'b0;    // core clock
  logic        reset_n = 1'b0; // reset
  logic [3:0]  gear = 4'h0;    // active gear
  logic [15:0] mode = 16'h0001;
  logic        load = 1'b0;    // protocol load pulse
  logic [11:0] dflt = 12'h9a5; // gain, corner, level, peak
  logic        cfg_rd;
  logic        busy;
  logic [7:0]  cfg_addr;
  logic [7:0]  cfg_data;
  wire  [11:0] got;
  int          err_total = 0;
  int          comparisons = 0;
  always #50 mclk = ~mclk;
  art_lut_update DUT (.mclk, .reset_n, .clk_en(1'b1), .power_gear(gear), .mode_onehot(mode),
    .protocol_load_cmd(load), .dflt_gain(dflt[11:10]), .dflt_hpcf(dflt[9:8]),
    .dflt_level(dflt[7:4]), .dflt_peak(dflt[3:0]), .cfg_rd, .cfg_addr, .cfg_data,
    .rx_gain(got[11:10]), .highpass_corner_select(got[9:8]), .signal_floor_level(got[7:4]),
    .signal_floor_peak_threshold(got[3:0]), .busy);
  art_store_model u_store (.mclk, .cfg_rd, .cfg_addr, .cfg_data);
  // reference fields from the table now held in the store
  function automatic logic [11:0] expect_out();
    int f [4] = '{dflt[11:10], dflt[9:8], dflt[7:4], dflt[3:0]};
    int lsb [4] = '{7, 4, 10, 13};
    int ws = u_store.mem[ART_SIZE_ADDR][3:0];
    logic [31:0] e;
    for (int i = 0; i < u_store.mem[ART_SIZE_ADDR][7:4] && i < ART_MAX_ENTRIES - ws; i++) begin
      for (int b = 0; b < 4; b++) e[8*b +: 8] = u_store.mem[ART_LUT_BASE + 8'(4*(ws+i)+b)];
      if (e[3:0] > gear) break;
      if ((e[31:16] & mode) == 16'h0) continue;
      for (int k = 0; k < 4; k++) begin
        f[k] += e[lsb[k]+2] ? -int'(e[lsb[k] +: 2]) : int'(e[lsb[k] +: 2]);
        f[k] = f[k] < 0 ? 0 : (f[k] > (k < 2 ? 3 : 15) ? (k < 2 ? 3 : 15) : f[k]);
      end
    end
    return {2'(f[0]), 2'(f[1]), 4'(f[2]), 4'(f[3])};
  endfunction
  // apply inputs, wait for six idle cycles, compare fields
  task automatic step(input logic [3:0] g, input logic [15:0] m, input logic [11:0] d,
                      input logic ld);
    logic [11:0] exp;
    @(posedge mclk);
    {gear, mode, dflt, load} <= {g, m, d, ld};
    @(posedge mclk);
    load <= 1'b0;
    for (int q = 0; q < 6; q = busy === 1'b0 ? q + 1 : 0) @(negedge mclk);
    exp = expect_out();
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: fields %h, expected %h", $time, got, exp);
    end
  endtask
  // size byte plus entries at the base the waveshape count implies
  task automatic load_table(input logic [3:0] rx, input logic [3:0] ws);
    logic [31:0] ent [3] = '{32'h0001ccd1, 32'h80117db2, 32'h8000e7e5};
    u_store.mem[ART_SIZE_ADDR] = {rx, ws};
    for (int a = 0; a < 80; a++) u_store.mem[ART_LUT_BASE + 8'(a)] = 8'hff;
    for (int i = 0; i < 12; i++) u_store.mem[ART_LUT_BASE + 8'(4*ws+i)] = ent[i/4][8*(i%4) +: 8];
  endtask
  task automatic stop_test();
    $display("TB: %0d mismatches in %0d comparisons", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    step(4'h0, 16'h0001, 12'h9a5, 1'b0);
    load_table(4'h3, 4'h2);
    for (int m = 0; m < 3; m++) begin
      step(4'h0, m == 0 ? 16'h0001 : m == 1 ? 16'h8000 : 16'h0010, 12'h9a5, 1'b1);
      for (int g = 1; g < 8; g++) step(4'(g % 7), mode, dflt, 1'b0);
    end
    step(4'h2, 16'h0001, 12'h0ff, 1'b1);
    @(posedge mclk) gear <= 4'h1;
    repeat (6) @(posedge mclk);
    step(4'h5, mode, dflt, 1'b0);
    load_table(4'h3, 4'h4);
    step(4'h6, mode, dflt, 1'b0);
    load_table(4'h9, 4'hf);
    step(4'hf, mode, dflt, 1'b0);
    load_table(4'h0, 4'h4);
    step(4'h2, mode, dflt, 1'b0);
    stop_test();
  end
  // watchdog at 20000 cycles, well beyond the roughly 940 cycles the sequence needs
  initial begin
    #2000000;
    err_total++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    stop_test();
  end
endmodule // art_lut_update_bench
bind art_lut_update art_lut_update_checker #(.MAX_ENTRIES(MAX_ENTRIES)) u_chk (.mclk, .reset_n,
  .protocol_load_cmd, .cfg_rd, .cfg_addr, .cfg_data, .rx_gain, .highpass_corner_select,
  .signal_floor_level, .signal_floor_peak_threshold, .busy);
